// ===== rtl/asc_defs.svh
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH
// ----------------------------------------------------------------
// Memory geometry
// ----------------------------------------------------------------
`define ASC_ADDR_W 13
`define ASC_DATA_W 8
`define ASC_WORDS 8192
// ----------------------------------------------------------------
// Timing in ns (slowest grade, so any grade is served)
// ----------------------------------------------------------------
`define ASC_CLK_NS 40
`define ASC_CYCLE_MIN_NS 200
`define ASC_ADDRESS_ACCESS_MAX_NS 200
`define ASC_DRIVE_TO_VALID_MAX_NS 90
`define ASC_WRITE_PULSE_MIN_NS 120
`define ASC_DATA_SETUP_MIN_NS 80
`define ASC_SELECT_TO_WRITE_END_MIN_NS 150
`define ASC_WRITE_RECOVERY_MIN_NS 15
`define ASC_DESELECT_TO_FLOAT_MAX_NS 80
`define ASC_WRITE_TO_FLOAT_MAX_NS 60
// ----------------------------------------------------------------
// Derived cycle counts (least and most times rounded up)
// ----------------------------------------------------------------
`define ASC_CEIL(ns) (((ns) + `ASC_CLK_NS - 1) / `ASC_CLK_NS)
// Active cycles are count minus one; selects lag the address by one
// Read: access time, one margin cycle, then two synchroniser stages
`define ASC_READ_CYC (`ASC_CEIL(`ASC_ADDRESS_ACCESS_MAX_NS) + 4)
// Write: selects held the full select-to-write-end time
`define ASC_WRITE_CYC (`ASC_CEIL(`ASC_SELECT_TO_WRITE_END_MIN_NS) + 1)
`define ASC_RECOVER_CYC `ASC_CEIL(`ASC_WRITE_RECOVERY_MIN_NS)
`define ASC_FLOAT_CYC `ASC_CEIL(`ASC_DESELECT_TO_FLOAT_MAX_NS)
`define ASC_CNT_W 4
`endif

// ===== rtl/asc_pkg.sv
`include "asc_defs.svh"
package asc_pkg;
  typedef logic [`ASC_ADDR_W-1:0] asc_addr_t;
  typedef logic [`ASC_DATA_W-1:0] asc_data_t;
  typedef enum logic [2:0] {
    ASC_IDLE, ASC_READ, ASC_WRITE, ASC_RECOVER, ASC_FLOAT
  } asc_state_e;
endpackage

// ===== rtl/asc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module asc_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end
  assign sync_out = sync_reg;
endmodule // asc_sync
`default_nettype wire

// ===== rtl/asc_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "asc_defs.svh"
// Overview of operation
// - Host spaces cycles by cycle minimum
// - Host holds write overlap long enough
// - Address stable before write overlap starts
// - Data setup, zero hold, address recovery
// - Address and selects held before write end
// - Host never drives against memory output
module asc_host
  import asc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  // User request side
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire asc_pkg::asc_addr_t req_addr_in,
  input wire asc_pkg::asc_data_t req_wdata_in,
  output logic req_ready_out,
  output logic rd_valid_out,
  output asc_pkg::asc_data_t rd_data_out,
  // Memory pins
  output asc_pkg::asc_addr_t word_address_out,
  output logic select_low_active_n_out,
  output logic select_high_active_out,
  output logic write_enable_n_out,
  output logic output_enable_n_out,
  input wire asc_pkg::asc_data_t data_pins_in,
  output asc_pkg::asc_data_t data_pins_out,
  output logic data_pins_oe_out
);
  import asc_pkg::*;
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  asc_state_e state_reg, state_next;
  logic [`ASC_CNT_W-1:0] cnt_reg, cnt_next;
  asc_addr_t addr_reg;
  asc_data_t wdata_reg;
  asc_data_t rdata_reg;
  logic rd_valid_reg;
  logic sel_reg, we_reg, oe_reg, drive_reg;
  asc_data_t data_sync;
  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  asc_sync #(.WIDTH(`ASC_DATA_W)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(data_pins_in),
    .sync_out(data_sync)
  );
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic cnt_done = (cnt_reg == '0);
  wire logic idle = (state_reg == ASC_IDLE);
  wire logic take = idle && req_valid_in;
  wire logic [`ASC_CNT_W-1:0] read_len = `ASC_CNT_W'(`ASC_READ_CYC - 1);
  wire logic [`ASC_CNT_W-1:0] write_len = `ASC_CNT_W'(`ASC_WRITE_CYC - 1);
  wire logic [`ASC_CNT_W-1:0] rec_len = `ASC_CNT_W'(`ASC_RECOVER_CYC - 1);
  wire logic [`ASC_CNT_W-1:0] float_len = `ASC_CNT_W'(`ASC_FLOAT_CYC - 1);
  assign req_ready_out = idle;
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_done ? cnt_reg : cnt_reg - `ASC_CNT_W'(1);
    case (state_reg)
      ASC_IDLE: begin
        if (take) begin
          // Cycle spacing met: read/write time covers cycle minimum
          state_next = req_write_in ? ASC_WRITE : ASC_READ;
          cnt_next = req_write_in ? write_len : read_len;
        end
      end
      ASC_READ: begin
        if (cnt_done) begin
          // Float margin before host may drive again
          state_next = ASC_FLOAT;
          cnt_next = float_len;
        end
      end
      ASC_WRITE: begin
        if (cnt_done) begin
          state_next = ASC_RECOVER;
          cnt_next = rec_len;
        end
      end
      ASC_RECOVER: begin
        if (cnt_done) begin
          state_next = ASC_IDLE;
        end
      end
      ASC_FLOAT: begin
        if (cnt_done) begin
          state_next = ASC_IDLE;
        end
      end
      default: begin
        state_next = ASC_IDLE;
        cnt_next = '0;
      end
    endcase
  end
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= ASC_IDLE;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end
  // Address and data latched at take: stable before selects rise
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_reg <= '0;
      wdata_reg <= '0;
    end else if (take) begin
      addr_reg <= req_addr_in;
      wdata_reg <= req_wdata_in;
    end
  end
  // ----------------------------------------------------------------
  // Pin strobes, all registered to avoid glitches
  // ----------------------------------------------------------------
  wire logic go_read = (state_next == ASC_READ);
  wire logic go_write = (state_next == ASC_WRITE);
  // Address set one cycle before selects, so setup is positive
  wire logic sel_next = (go_read && !take) || (go_write && !take);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sel_reg <= 1'b0;
      we_reg <= 1'b0;
      oe_reg <= 1'b0;
      drive_reg <= 1'b0;
    end else begin
      sel_reg <= sel_next;
      we_reg <= go_write && !take;
      oe_reg <= go_read && !take;
      // Drive only in write phase; memory output off there
      drive_reg <= go_write && !take;
    end
  end
  assign word_address_out = addr_reg;
  assign select_low_active_n_out = !sel_reg;
  assign select_high_active_out = sel_reg;
  assign write_enable_n_out = !we_reg;
  assign output_enable_n_out = !oe_reg;
  assign data_pins_out = wdata_reg;
  assign data_pins_oe_out = drive_reg;
  // ----------------------------------------------------------------
  // Read capture: sampled at end of read phase, after access time
  // plus synchroniser latency
  // ----------------------------------------------------------------
  wire logic capture = (state_reg == ASC_READ) && cnt_done;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg <= '0;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= capture;
      if (capture) begin
        rdata_reg <= data_sync;
      end
    end
  end
  assign rd_valid_out = rd_valid_reg;
  assign rd_data_out = rdata_reg;
endmodule // asc_host
`default_nettype wire

// ===== tb/asc_host_properties.sv
`timescale 1ns/1ps
`default_nettype none
module asc_host_properties (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_ready_out,
  input wire logic rd_valid_out,
  input wire asc_pkg::asc_addr_t word_address_out,
  input wire logic select_low_active_n_out,
  input wire logic select_high_active_out,
  input wire logic write_enable_n_out,
  input wire logic output_enable_n_out,
  input wire asc_pkg::asc_data_t data_pins_out,
  input wire logic data_pins_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire wr = !write_enable_n_out;
  wire sn = select_low_active_n_out;
  chk_sel_pair: assert property (sn == !select_high_active_out)
    else $error("selects disagree");
  chk_write_len: assert property ($fell(write_enable_n_out) |-> wr [*3])
    else $error("write pulse short");
  chk_sel_len: assert property ($fell(sn) |-> !sn [*4])
    else $error("select too short");
  chk_write_sel: assert property (wr |-> !sn && select_high_active_out)
    else $error("write without select");
  chk_addr_hold: assert property (wr |-> $stable(word_address_out))
    else $error("address moved in write");
  chk_data_hold: assert property (wr && $past(wr) |-> $stable(data_pins_out))
    else $error("data moved in write");
  chk_addr_recover: assert property ($rose(write_enable_n_out) |-> $stable(word_address_out))
    else $error("address moved at write end");
  chk_no_fight: assert property (data_pins_oe_out |-> wr)
    else $error("host drives outside write");
  chk_deselect_gap: assert property ($rose(sn) |=> sn)
    else $error("cycle too close");
  chk_read_answer: assert property (req_valid_in && req_ready_out && !req_write_in
    |=> !req_ready_out ##9 rd_valid_out)
    else $error("read not answered");
  chk_oe_drive: assert property (data_pins_oe_out |-> output_enable_n_out)
    else $error("host drives with output enable on");
  chk_read_oe: assert property (!output_enable_n_out |-> write_enable_n_out && !sn)
    else $error("output enable outside read");
endmodule // asc_host_properties
bind asc_host asc_host_properties u_chk (
  .clk_in(clk_in),
  .rst_in(rst_in),
  .req_valid_in(req_valid_in),
  .req_write_in(req_write_in),
  .req_ready_out(req_ready_out),
  .rd_valid_out(rd_valid_out),
  .word_address_out(word_address_out),
  .select_low_active_n_out(select_low_active_n_out),
  .select_high_active_out(select_high_active_out),
  .write_enable_n_out(write_enable_n_out),
  .output_enable_n_out(output_enable_n_out),
  .data_pins_out(data_pins_out),
  .data_pins_oe_out(data_pins_oe_out)
);
`default_nettype wire

// ===== tb/asc_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
module asc_sram_model #(
  parameter int ACC_NS = 200
) (
  input wire logic [12:0] addr_in,
  input wire logic sel_n_in,
  input wire logic sel_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic [7:0] d_in,
  output logic [7:0] q_out,
  output logic drv_out
);
  logic [7:0] mem [8192];
  logic [7:0] d_dly;
  logic [12:0] a_dly;
  wire on = !sel_n_in && sel_in;
  wire wr = on && !we_n_in;
  wire rd = on && we_n_in && !oe_n_in;
  initial drv_out = 1'b0;
  // Values from just before the edge, so zero hold is enough
  always @(d_in, addr_in) begin
    d_dly <= #1 d_in;
    a_dly <= #1 addr_in;
  end
  always @(negedge wr) mem[a_dly] = d_dly;
  always @(addr_in, rd) q_out <= #ACC_NS mem[addr_in];
  always @(rd) drv_out <= #10 rd;
endmodule // asc_sram_model
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import asc_pkg::*;
  logic clk_in = 0, rst_in = 1, v = 0, w = 0, hoe, mdrv, sn, sh, wen, oen, rv, rdy;
  asc_addr_t a = '0, wa;
  asc_data_t wd = '0, dout, q, rdat, bus, flt = 8'h5A;
  int err_count = 0, checks_done = 0;
  always #20 clk_in = ~clk_in;
  // Undriven bus shows a changing pattern, never a stale value
  always @(posedge clk_in) flt <= ~flt;
  assign bus = hoe ? dout : (mdrv ? q : flt);
  asc_host dut (.clk_in(clk_in), .rst_in(rst_in), .req_valid_in(v), .req_write_in(w),
    .req_addr_in(a), .req_wdata_in(wd), .req_ready_out(rdy), .rd_valid_out(rv),
    .rd_data_out(rdat), .word_address_out(wa), .select_low_active_n_out(sn),
    .select_high_active_out(sh), .write_enable_n_out(wen), .output_enable_n_out(oen),
    .data_pins_in(bus), .data_pins_out(dout), .data_pins_oe_out(hoe));
  asc_sram_model mem (.addr_in(wa), .sel_n_in(sn), .sel_in(sh), .we_n_in(wen),
    .oe_n_in(oen), .d_in(bus), .q_out(q), .drv_out(mdrv));
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic op(input logic wr, input asc_addr_t ad, input asc_data_t d);
    int n = 0;
    @(negedge clk_in);
    {v, w, a, wd} = {1'b1, wr, ad, d};
    // Ready looked at off the edge, where it has settled
    while (rdy !== 1'b1 && n < 20) begin
      @(negedge clk_in);
      n++;
    end
    @(posedge clk_in);
    @(negedge clk_in);
    v = 0;
    if (n >= 20) begin
      err_count++;
      conclude;
    end
  endtask
  task automatic rd(input asc_addr_t ad, input asc_data_t exp);
    int n = 0;
    op(0, ad, 8'h00);
    while (rv !== 1'b1 && n < 12) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 12) begin
      err_count++;
      conclude;
    end
    check(rdat, exp);
  endtask
  task automatic t_reset;
    check({7'h00, sn}, 8'h01);
    check({7'h00, sh | hoe | ~rdy}, 8'h00);
    check({6'h00, wen, oen}, 8'h03);
    check(wa[7:0], 8'h00);
  endtask
  task automatic t_rw;
    asc_addr_t ad [4] = '{13'h0000, 13'h1FFF, 13'h0AAA, 13'h1555};
    for (int i = 0; i < 4; i++) op(1, ad[i], 8'h3C ^ ad[i][7:0]);
    for (int i = 0; i < 4; i++) rd(ad[i], 8'h3C ^ ad[i][7:0]);
  endtask
  task automatic t_over;
    op(1, 13'h0123, 8'hA5);
    op(1, 13'h0123, 8'h5A);
    rd(13'h0123, 8'h5A);
    op(1, 13'h0124, 8'hFF);
    rd(13'h0123, 8'h5A);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    t_reset;
    rst_in = 0;
    t_rw;
    t_over;
    conclude;
  end
endmodule // tb_top
`default_nettype wire
